/* File: rtl/rx_overhead_capture_regs.sv */
// Receive overhead capture and status registers, four port copies.
// Assumes framer events are one-cycle pulses synchronous to clk_sys_in.
//
// Decided for this implementation: the plain strobed port.
`default_nettype none
module rx_overhead_capture_regs #(
    parameter logic [7:0] FW_REVISION = 8'h01, // Arbitrary value
    parameter int NUM_PORTS = 4
) (
    input wire logic clk_sys_in,                    // System clock
    input wire logic rst_n_in,                      // Sync reset, low
    input wire logic [10:0] addr_in,                // Byte address
    input wire logic rd_in,                         // Read strobe
    input wire logic wr_in,                         // Write strobe, ignored
    input wire logic [7:0] wdata_in,                // Write data, ignored
    input wire rx_ovh_pkg::rx_evt_s evt_in [NUM_PORTS], // Framer events
    output logic [7:0] rdata_out,                   // Read data
    output logic rvalid_out                         // Read data valid
);
    import rx_ovh_pkg::*;

    initial begin
        if (NUM_PORTS != PORTS) begin
            $error("NUM_PORTS must be 4");
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] link;
        logic [7:0] link_shift;
        logic [2:0] link_cnt;
        logic [CODE_W-1:0] code;
        logic [CNT_W-1:0] cnt;
        logic [2:0] hunt;
        logic [7:0] align;
        logic [7:0] nonalign;
        logic [7:0] si_even;
        logic [7:0] si_odd;
        logic [7:0] remote;
        logic [7:0] spare4;
        logic [7:0] si_even_acc;
        logic [7:0] si_odd_acc;
        logic [7:0] remote_acc;
        logic [7:0] spare4_acc;
        logic [7:0] slc1;
        logic [7:0] slc2;
        logic [7:0] slc3;
    } port_s;

    typedef struct packed {
        port_s [PORTS-1:0] port;
        logic [7:0] rdata;
        logic rvalid;
    } state_s;

    state_s state_q;
    state_s state_d;

    // Place a captured bit in its slot within a gathered byte
    function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] idx,
                                            input logic v);
        logic [7:0] r;
        r = b;
        r[idx] = v;
        return r;
    endfunction

    function automatic logic [7:0] sync_status(input port_s p);
        return {p.cnt[5:2], p.cnt[0], p.hunt};
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [1:0] sel_port;
    logic [8:0] sel_ofs;
    assign sel_port = addr_in[10:9];
    assign sel_ofs = addr_in[8:0];

    always_comb begin
        port_s p;
        rx_evt_s e;
        p = '0;
        e = '0;
        state_d = state_q;
        for (int i = 0; i < PORTS; i++) begin
            p = state_q.port[i];
            e = evt_in[i];
            // Live status, never latched
            p.hunt = {e.crc4_hunt, e.cas_hunt, e.fas_hunt};
            if (!e.crc4_enable || e.crc4_locked) begin
                p.cnt = '0;
            end else if (e.crc4_timeout && p.cnt != CNT_MAX) begin
                p.cnt = p.cnt + 6'h01;
            end
            if (e.code_valid) begin
                p.code = e.code;
            end
            if (!e.e1_mode) begin
                // Shift right so the first received bit ends in bit 0
                if (e.link_bit_valid) begin
                    p.link_shift = {e.link_bit, p.link_shift[7:1]};
                    p.link_cnt = p.link_cnt + 3'h1;
                    if (!e.d4_mode && p.link_cnt == 3'h7) begin
                        p.link = {e.link_bit, p.link_shift[7:1]};
                    end
                end
                if (e.d4_mode && e.mf_boundary) begin
                    // Six Fs bits right-justified in 5:0
                    p.link = {2'b00, p.link_shift[7:2]};
                    p.link_cnt = 3'h0;
                end
                if (e.slc_valid) begin
                    p.slc1 = e.slc_bits[23:16];
                    p.slc2 = e.slc_bits[15:8];
                    p.slc3 = e.slc_bits[7:0];
                end
            end else if (e.ts0_valid) begin
                if (!e.frame_num[0]) begin
                    p.align = e.ts0_byte;
                    p.si_even_acc = put_bit(p.si_even_acc, e.frame_num[3:1],
                                            e.ts0_byte[7]);
                end else begin
                    p.nonalign = e.ts0_byte;
                    p.si_odd_acc = put_bit(p.si_odd_acc, e.frame_num[3:1],
                                           e.ts0_byte[7]);
                    p.remote_acc = put_bit(p.remote_acc, e.frame_num[3:1],
                                           e.ts0_byte[5]);
                    p.spare4_acc = put_bit(p.spare4_acc, e.frame_num[3:1],
                                           e.ts0_byte[4]);
                end
                if (e.frame_num == LAST_FRAME) begin
                    // Whole-byte load keeps one multiframe per read
                    p.si_even = p.si_even_acc;
                    p.si_odd = p.si_odd_acc;
                    p.remote = p.remote_acc;
                    p.spare4 = p.spare4_acc;
                end
            end
            state_d.port[i] = p;
        end

        // --------------------------------------------------------
        // Read decode, data valid one cycle after the strobe
        // --------------------------------------------------------
        state_d.rvalid = rd_in;
        state_d.rdata = RESET_BYTE;
        if (rd_in) begin
            p = state_q.port[sel_port];
            e = evt_in[sel_port];
            unique case (sel_ofs)
                OFS_REVISION: state_d.rdata = FW_REVISION;
                OFS_LINK_BYTE: state_d.rdata = e.e1_mode ? sync_status(p) : p.link;
                OFS_CODE: state_d.rdata = {2'b00, p.code};
                OFS_ALIGN: state_d.rdata = e.e1_mode ? p.align : p.slc1;
                OFS_NONALIGN: state_d.rdata = e.e1_mode ? p.nonalign : p.slc2;
                OFS_SI_EVEN: state_d.rdata = e.e1_mode ? p.si_even : p.slc3;
                OFS_SI_ODD: state_d.rdata = p.si_odd;
                OFS_REMOTE: state_d.rdata = p.remote;
                OFS_SPARE4: state_d.rdata = p.spare4;
                default: state_d.rdata = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign rdata_out = state_q.rdata;
    assign rvalid_out = state_q.rvalid;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    counter_clear_a: assert property (!evt_in[0].crc4_enable |=> state_q.port[0].cnt == 6'h00)
        else $error("counter not cleared");
    lock_clear_a: assert property (evt_in[0].crc4_locked |=> state_q.port[0].cnt == 6'h00)
        else $error("counter not cleared on lock");
    counter_step_a: assert property (evt_in[0].crc4_enable && !evt_in[0].crc4_locked
            && evt_in[0].crc4_timeout && state_q.port[0].cnt != 6'h3F
            |=> state_q.port[0].cnt == $past(state_q.port[0].cnt) + 6'h01)
        else $error("counter missed step");
    counter_sat_a: assert property (state_q.port[0].cnt == 6'h3F && evt_in[0].crc4_enable
            && !evt_in[0].crc4_locked |=> state_q.port[0].cnt == 6'h3F)
        else $error("counter wrapped");
    hunt_live_a: assert property (1'b1 |=> state_q.port[0].hunt == $past({evt_in[0].crc4_hunt,
            evt_in[0].cas_hunt, evt_in[0].fas_hunt}))
        else $error("hunt status stale");
    code_hold_a: assert property (!evt_in[0].code_valid |=> $stable(state_q.port[0].code))
        else $error("code changed without valid");
    revision_read_a: assert property (rd_in && addr_in[8:0] == 9'h061
            |=> rvalid_out && rdata_out == FW_REVISION)
        else $error("revision read wrong");
    status_read_a: assert property (rd_in && addr_in == 11'h662 && evt_in[3].e1_mode
            |=> rdata_out[2:0] == $past(state_q.port[3].hunt)
                && rdata_out[7:3] == $past({state_q.port[3].cnt[5:2], state_q.port[3].cnt[0]}))
        else $error("status layout wrong");
    read_one_a: assert property (rvalid_out |=> !rvalid_out || $past(rd_in))
        else $error("read valid too long");
    read_idle_a: assert property (!rd_in |=> !rvalid_out && rdata_out == 8'h00)
        else $error("read data outside its cycle");

    // ------------------------------------------------------------
    // Per-port checks: every copy of the group must behave alike
    // ------------------------------------------------------------
    for (genvar g = 0; g < PORTS; g++) begin : g_port_chk
        link_load_a: assert property (
            !evt_in[g].e1_mode && !evt_in[g].d4_mode && evt_in[g].link_bit_valid
                && state_q.port[g].link_cnt == 3'h7
            |=> state_q.port[g].link == {$past(evt_in[g].link_bit),
                $past(state_q.port[g].link_shift[7:1])})
            else $error("link byte not loaded");
        link_hold_a: assert property (
            !evt_in[g].e1_mode && !evt_in[g].d4_mode && !evt_in[g].link_bit_valid
            |=> $stable(state_q.port[g].link))
            else $error("link byte changed without a bit");
        shift_order_a: assert property (
            !evt_in[g].e1_mode && evt_in[g].link_bit_valid
            |=> state_q.port[g].link_shift[7] == $past(evt_in[g].link_bit)
                && state_q.port[g].link_shift[6:0] == $past(state_q.port[g].link_shift[7:1]))
            else $error("link bit order wrong");
        d4_load_a: assert property (
            !evt_in[g].e1_mode && evt_in[g].d4_mode && evt_in[g].mf_boundary
                && !evt_in[g].link_bit_valid
            |=> state_q.port[g].link == {2'b00, $past(state_q.port[g].link_shift[7:2])})
            else $error("six framing bits not loaded");
        d4_hold_a: assert property (
            !evt_in[g].e1_mode && evt_in[g].d4_mode && !evt_in[g].mf_boundary
            |=> $stable(state_q.port[g].link))
            else $error("link byte changed inside multiframe");

        code_take_a: assert property (
            evt_in[g].code_valid
            |=> state_q.port[g].code == $past(evt_in[g].code))
            else $error("valid code not kept");
        code_read_a: assert property (
            rd_in && addr_in[10:9] == 2'(g) && addr_in[8:0] == OFS_CODE
            |=> rdata_out == {2'b00, $past(state_q.port[g].code)})
            else $error("code read wrong");
        link_read_a: assert property (
            rd_in && addr_in[10:9] == 2'(g) && addr_in[8:0] == OFS_LINK_BYTE
                && !evt_in[g].e1_mode
            |=> rdata_out == $past(state_q.port[g].link))
            else $error("link byte read wrong");

        clear_wins_a: assert property (
            evt_in[g].crc4_timeout && (!evt_in[g].crc4_enable || evt_in[g].crc4_locked)
            |=> state_q.port[g].cnt == 6'h00)
            else $error("counter not cleared on a timeout");
        cnt_step_a: assert property (
            evt_in[g].crc4_enable && !evt_in[g].crc4_locked && evt_in[g].crc4_timeout
                && state_q.port[g].cnt != CNT_MAX
            |=> state_q.port[g].cnt == $past(state_q.port[g].cnt) + 6'h01)
            else $error("counter missed a step");
        cnt_idle_a: assert property (
            evt_in[g].crc4_enable && !evt_in[g].crc4_locked && !evt_in[g].crc4_timeout
            |=> $stable(state_q.port[g].cnt))
            else $error("counter moved without a timeout");
        hunt_follow_a: assert property (
            1'b1 |=> state_q.port[g].hunt == $past({evt_in[g].crc4_hunt,
                evt_in[g].cas_hunt, evt_in[g].fas_hunt}))
            else $error("hunt status stale");

        slc_load_a: assert property (
            !evt_in[g].e1_mode && evt_in[g].slc_valid
            |=> {state_q.port[g].slc1, state_q.port[g].slc2, state_q.port[g].slc3}
                == $past(evt_in[g].slc_bits))
            else $error("link words not taken");
        slc_read_a: assert property (
            rd_in && addr_in[10:9] == 2'(g) && addr_in[8:0] == OFS_ALIGN
                && !evt_in[g].e1_mode
            |=> rdata_out == $past(state_q.port[g].slc1))
            else $error("first link word read wrong");

        align_cap_a: assert property (
            evt_in[g].e1_mode && evt_in[g].ts0_valid && !evt_in[g].frame_num[0]
            |=> state_q.port[g].align == $past(evt_in[g].ts0_byte))
            else $error("align byte not captured");
        nonalign_cap_a: assert property (
            evt_in[g].e1_mode && evt_in[g].ts0_valid && evt_in[g].frame_num[0]
            |=> state_q.port[g].nonalign == $past(evt_in[g].ts0_byte))
            else $error("non-align byte not captured");
        even_slot_a: assert property (
            evt_in[g].e1_mode && evt_in[g].ts0_valid && !evt_in[g].frame_num[0]
            |=> state_q.port[g].si_even_acc[$past(evt_in[g].frame_num[3:1])]
                == $past(evt_in[g].ts0_byte[7]))
            else $error("even frame bit misplaced");
        odd_slot_a: assert property (
            evt_in[g].e1_mode && evt_in[g].ts0_valid && evt_in[g].frame_num[0]
            |=> state_q.port[g].si_odd_acc[$past(evt_in[g].frame_num[3:1])]
                    == $past(evt_in[g].ts0_byte[7])
                && state_q.port[g].remote_acc[$past(evt_in[g].frame_num[3:1])]
                    == $past(evt_in[g].ts0_byte[5]))
            else $error("odd frame bit misplaced");
        publish_a: assert property (
            evt_in[g].e1_mode && evt_in[g].ts0_valid && evt_in[g].frame_num == LAST_FRAME
            |=> state_q.port[g].si_odd[7] == $past(evt_in[g].ts0_byte[7])
                && state_q.port[g].si_odd[6:0] == $past(state_q.port[g].si_odd_acc[6:0])
                && state_q.port[g].si_even == $past(state_q.port[g].si_even_acc))
            else $error("gathered bytes not published");
        publish_hold_a: assert property (
            !(evt_in[g].e1_mode && evt_in[g].ts0_valid && evt_in[g].frame_num == LAST_FRAME)
            |=> $stable(state_q.port[g].si_even) && $stable(state_q.port[g].si_odd)
                && $stable(state_q.port[g].remote) && $stable(state_q.port[g].spare4))
            else $error("gathered bytes changed mid multiframe");

        align_read_a: assert property (
            rd_in && addr_in[10:9] == 2'(g) && addr_in[8:0] == OFS_ALIGN
                && evt_in[g].e1_mode
            |=> rdata_out == $past(state_q.port[g].align))
            else $error("align byte read wrong");
        odd_read_a: assert property (
            rd_in && addr_in[10:9] == 2'(g) && addr_in[8:0] == OFS_SI_ODD
            |=> rdata_out == $past(state_q.port[g].si_odd))
            else $error("odd frame byte read wrong");
        remote_read_a: assert property (
            rd_in && addr_in[10:9] == 2'(g) && addr_in[8:0] == OFS_REMOTE
            |=> rdata_out == $past(state_q.port[g].remote))
            else $error("alarm byte read wrong");
        spare_read_a: assert property (
            rd_in && addr_in[10:9] == 2'(g) && addr_in[8:0] == OFS_SPARE4
            |=> rdata_out == $past(state_q.port[g].spare4))
            else $error("spare byte read wrong");
        rev_port_a: assert property (
            rd_in && addr_in[10:9] == 2'(g) && addr_in[8:0] == OFS_REVISION
            |=> rdata_out == FW_REVISION)
            else $error("revision read wrong on a port");
    end

    read_cov_c: cover property (rd_in ##1 rvalid_out);
    sat_cov_c: cover property (state_q.port[0].cnt == 6'h3F);
    mf_cov_c: cover property (evt_in[0].ts0_valid && evt_in[0].frame_num == 4'hF);
    d4_cov_c: cover property (evt_in[0].d4_mode && evt_in[0].mf_boundary);
endmodule // rx_overhead_capture_regs
`default_nettype wire

/* File: include/rx_ovh_pkg.sv */
// Package for the receive overhead capture register group.
// Assumes one system clock; register port is a plain strobe port.
`default_nettype none
package rx_ovh_pkg;
    // ------------------------------------------------------------
    // Register map (byte offsets within a port copy)
    // ------------------------------------------------------------
    localparam logic [11:0] PORT_STRIDE = 12'h200;
    localparam logic [8:0] OFS_REVISION = 9'h061;
    localparam logic [8:0] OFS_LINK_BYTE = 9'h062;
    localparam logic [8:0] OFS_CODE = 9'h063;
    localparam logic [8:0] OFS_ALIGN = 9'h064;
    localparam logic [8:0] OFS_NONALIGN = 9'h065;
    localparam logic [8:0] OFS_SI_EVEN = 9'h066;
    localparam logic [8:0] OFS_SI_ODD = 9'h067;
    localparam logic [8:0] OFS_REMOTE = 9'h068;
    localparam logic [8:0] OFS_SPARE4 = 9'h069;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int CODE_W = 6;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
    // Search window figure, in milliseconds
    localparam int CRC4_SEARCH_MS = 8;
    localparam int PORTS = 4;
    localparam logic [3:0] LAST_FRAME = 4'hF;

    // Receive framer events and data for one port
    typedef struct packed {
        logic e1_mode;          // 1 = E1, 0 = T1
        logic d4_mode;          // T1 D4 framing
        logic crc4_enable;      // receive control bit 3
        logic link_bit_valid;   // one received link / Fs bit
        logic link_bit;
        logic mf_boundary;      // T1 multiframe boundary
        logic code_valid;       // valid bit-oriented code seen
        logic [CODE_W-1:0] code;
        logic crc4_timeout;     // 8 ms search expired
        logic crc4_locked;      // CRC-4 multiframe alignment gained
        logic crc4_hunt;
        logic cas_hunt;
        logic fas_hunt;
        logic ts0_valid;        // timeslot-0 byte of a frame
        logic [3:0] frame_num;  // 0..15 within multiframe
        logic [7:0] ts0_byte;
        logic slc_valid;        // SLC-96 link words ready
        logic [23:0] slc_bits;  // {link one, two, three}
    } rx_evt_s;
endpackage : rx_ovh_pkg
`default_nettype wire

/* File: test/rx_line_model.sv */
// Far-side framer model: drives per-port receive events into the capture block.
// Assumes the bench calls fire() from one process per port at a time.
`default_nettype none
module rx_line_model (
    input wire logic clk_sys_in,                     // System clock
    output var rx_ovh_pkg::rx_evt_s evt_out [4]      // Events per port
);
    timeunit 1ns;
    timeprecision 1ps;
    import rx_ovh_pkg::*;
    // ------------------------------------------------------------
    // Event driver
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 4; i++) begin
            evt_out[i] = '0;
        end
    end
    // One-cycle pulse, then data lines flip so stale values never look valid
    task automatic fire(input int p, input rx_evt_s e);
        rx_evt_s idle;
        idle = e;
        {idle.link_bit_valid, idle.mf_boundary, idle.code_valid} = 3'h0;
        {idle.crc4_timeout, idle.crc4_locked, idle.ts0_valid, idle.slc_valid} = 4'h0;
        idle.link_bit = ~e.link_bit;
        idle.code = ~e.code;
        idle.ts0_byte = ~e.ts0_byte;
        idle.frame_num = ~e.frame_num;
        idle.slc_bits = ~e.slc_bits;
        @(posedge clk_sys_in);
        evt_out[p] <= e;
        @(posedge clk_sys_in);
        evt_out[p] <= idle;
    endtask
endmodule // rx_line_model
`default_nettype wire

/* File: test/rx_overhead_capture_regs_tb_top.sv */
// Bench for the receive overhead capture registers: register reads and framer events.
// Assumes the partner model in rx_line_model.sv and the package rx_ovh_pkg.
`default_nettype none
module rx_overhead_capture_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rx_ovh_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [10:0] addr_in = 11'h000;
    logic rd_in = 1'b0;
    logic wr_in = 1'b0;
    logic [7:0] wdata_in = 8'h00;
    logic [7:0] rdata_out;
    logic rvalid_out;
    rx_evt_s evt [4];
    rx_evt_s base [4];
    rx_evt_s e;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2 clk_sys_in = ~clk_sys_in;
    rx_line_model rx_line_model_i (.clk_sys_in(clk_sys_in), .evt_out(evt));
    rx_overhead_capture_regs #(.FW_REVISION(8'h5A)) rx_overhead_capture_regs_i (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .rd_in(rd_in),
        .wr_in(wr_in), .wdata_in(wdata_in), .evt_in(evt), .rdata_out(rdata_out),
        .rvalid_out(rvalid_out));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [1:0] p, input logic [8:0] ofs, input logic [7:0] exp);
        @(posedge clk_sys_in);
        rd_in <= 1'b1;
        addr_in <= {p, ofs};
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 check({rvalid_out, rdata_out}, {1'b1, exp});
    endtask
    task automatic tmo(input int n);
        for (int i = 0; i < n; i++) begin
            e = base[3];
            e.crc4_timeout = 1'b1;
            rx_line_model_i.fire(3, e);
        end
    endtask
    // Hang guard; the whole run needs a few hundred cycles
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 4; i++) begin
            base[i] = '0;
        end
        repeat (16) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd_chk(0, OFS_REVISION, 8'h5A);
        for (int o = 'h62; o <= 'h69; o++) begin
            rd_chk(0, 9'(o), RESET_BYTE);
        end
        rd_chk(0, 9'h070, 8'h00);
        for (int i = 0; i < 8; i++) begin
            e = base[1];
            e.link_bit_valid = 1'b1;
            e.link_bit = 1'(8'hC3 >> i);
            rx_line_model_i.fire(1, e);
        end
        rd_chk(1, OFS_LINK_BYTE, 8'hC3);
        e = base[1];
        e.code_valid = 1'b1;
        e.code = 6'h2A;
        rx_line_model_i.fire(1, e);
        @(posedge clk_sys_in);
        wr_in <= 1'b1;
        addr_in <= {2'h1, OFS_CODE};
        wdata_in <= 8'hFF;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        rd_chk(1, OFS_CODE, 8'h2A);
        base[1].d4_mode = 1'b1;
        for (int i = 0; i < 6; i++) begin
            e = base[1];
            e.link_bit_valid = 1'b1;
            e.link_bit = 1'(6'h2D >> i);
            rx_line_model_i.fire(1, e);
        end
        rd_chk(1, OFS_LINK_BYTE, 8'hC3);
        e = base[1];
        e.mf_boundary = 1'b1;
        rx_line_model_i.fire(1, e);
        rd_chk(1, OFS_LINK_BYTE, 8'h2D);
        e = base[2];
        e.slc_valid = 1'b1;
        e.slc_bits = 24'h123456;
        rx_line_model_i.fire(2, e);
        rd_chk(2, OFS_ALIGN, 8'h12);
        rd_chk(2, OFS_NONALIGN, 8'h34);
        rd_chk(2, OFS_SI_EVEN, 8'h56);
        // Status byte is {cnt[5:2], cnt[0], crc4 hunt, cas hunt, fas hunt}
        base[3].e1_mode = 1'b1;
        base[3].crc4_enable = 1'b1;
        {base[3].crc4_hunt, base[3].cas_hunt, base[3].fas_hunt} = 3'b101;
        tmo(3);
        rd_chk(3, OFS_LINK_BYTE, 8'h0D);
        tmo(70);
        rd_chk(3, OFS_LINK_BYTE, 8'hFD);
        {base[3].crc4_hunt, base[3].cas_hunt, base[3].fas_hunt} = 3'b010;
        e = base[3];
        e.crc4_locked = 1'b1;
        rx_line_model_i.fire(3, e);
        rd_chk(3, OFS_LINK_BYTE, 8'h02);
        base[3].crc4_hunt = 1'b1;
        tmo(2);
        rd_chk(3, OFS_LINK_BYTE, 8'h06);
        tmo(1);
        rd_chk(3, OFS_LINK_BYTE, 8'h0E);
        // A bench standing in for software would give up here after 400 ms
        base[3].crc4_enable = 1'b0;
        rx_line_model_i.fire(3, base[3]);
        rd_chk(3, OFS_LINK_BYTE, 8'h06);
        for (int m = 0; m < 32; m++) begin
            e = base[3];
            e.ts0_valid = 1'b1;
            e.frame_num = 4'(m);
            e.ts0_byte = m[0] ? {1'(8'h5C >> m[3:1]), 1'b1, 1'(8'hA3 >> m[3:1]),
                1'(8'h3E >> m[3:1]), 4'h5} : {1'(8'h96 >> m[3:1]), 7'h1B};
            rx_line_model_i.fire(3, e);
        end
        rd_chk(3, OFS_ALIGN, 8'h9B);
        rd_chk(3, OFS_NONALIGN, 8'h65);
        rd_chk(3, OFS_SI_EVEN, 8'h96);
        rd_chk(3, OFS_SI_ODD, 8'h5C);
        rd_chk(3, OFS_REMOTE, 8'hA3);
        rd_chk(3, OFS_SPARE4, 8'h3E);
        report_and_stop();
    end
endmodule // rx_overhead_capture_regs_tb_top
`default_nettype wire
